// >>> src/ccv_regs.sv
// special-function access path to three capture/compare values
`timescale 1ns/1ns
`default_nettype none
module ccv_regs #(
	parameter int NUM_MODULES = ccv_pkg::NUM_MODULES
) (
	input  wire logic                       sys_clk,
	input  wire logic                       reset_n,
	input  wire ccv_pkg::ccv_sfr_req_t      sfr_req,
	input  wire logic                       reload_select,
	input  wire logic [NUM_MODULES-1:0]     counter_match,
	output logic [7:0]                      sfr_rdata,
	output logic                            sfr_hit,
	output logic [NUM_MODULES*16-1:0]       compare_value,
	output logic [NUM_MODULES*16-1:0]       reload_value,
	output logic [NUM_MODULES-1:0]          compare_enable,
	output logic [NUM_MODULES-1:0]          module_output_pin
);
	localparam logic [7:0] LOW_ADDR [3]  = '{ccv_pkg::ADDR_LOW_0, ccv_pkg::ADDR_LOW_1,
		ccv_pkg::ADDR_LOW_2};
	localparam logic [7:0] HIGH_ADDR [3] = '{ccv_pkg::ADDR_HIGH_0, ccv_pkg::ADDR_HIGH_1,
		ccv_pkg::ADDR_HIGH_2};

	logic [NUM_MODULES-1:0] hit_low;
	logic [NUM_MODULES-1:0] hit_high;
	logic [15:0]            sel_val [NUM_MODULES];
	logic [7:0]             rdata_d;
	logic [7:0]             rdata_q;
	logic                   hit_d;
	logic                   hit_q;

	genvar g;
	generate
		for (g = 0; g < NUM_MODULES; g++) begin : g_mod
			assign hit_low[g]  = (sfr_req.addr == LOW_ADDR[g]);
			assign hit_high[g] = (sfr_req.addr == HIGH_ADDR[g]);
			ccv_channel u_chan (
				.sys_clk           (sys_clk),
				.reset_n           (reset_n),
				.reload_select     (reload_select),
				.wr_low            (sfr_req.wr && hit_low[g]),
				.wr_high           (sfr_req.wr && hit_high[g]),
				.wdata             (sfr_req.wdata),
				.counter_match     (counter_match[g]),
				.selected_value    (sel_val[g]),
				.compare_value     (compare_value[g*16 +: 16]),
				.reload_value      (reload_value[g*16 +: 16]),
				.compare_enable    (compare_enable[g]),
				.module_output_pin (module_output_pin[g])
			);
		end
	endgenerate

	// read mux; reads only select, never write back
	always_comb begin
		rdata_d = 8'h00;
		hit_d   = 1'b0;
		for (int i = 0; i < NUM_MODULES; i++) begin
			if (hit_low[i]) begin
				rdata_d = sel_val[i][7:0];
				hit_d   = 1'b1;
			end
			if (hit_high[i]) begin
				rdata_d = sel_val[i][15:8];
				hit_d   = 1'b1;
			end
		end
	end

	// registered read data, one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end else begin
			rdata_q <= sfr_req.rd ? rdata_d : 8'h00;
			hit_q   <= sfr_req.rd && hit_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign sfr_hit   = hit_q;

	chk_read_low0: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(sfr_req.rd && sfr_req.addr == ccv_pkg::ADDR_LOW_0) |=> sfr_hit
		&& sfr_rdata == $past(sel_val[0][7:0])) else $error("module 0 low read wrong");
	chk_read_high2: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(sfr_req.rd && sfr_req.addr == ccv_pkg::ADDR_HIGH_2) |=> sfr_hit
		&& sfr_rdata == $past(sel_val[2][15:8])) else $error("module 2 high read wrong");
	chk_read_no_effect: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(sfr_req.rd && !sfr_req.wr) |=> $stable(compare_enable)) else $error("read changed enable");
	cov_unmapped_read: cover property (@(posedge sys_clk) disable iff (!reset_n)
		sfr_req.rd && !hit_d);
endmodule : ccv_regs
`default_nettype wire

// >>> src/ccv_pkg.sv
// package for the capture/compare value register block
package ccv_pkg;
	localparam int          NUM_MODULES = 3;
	localparam logic [7:0]  ADDR_LOW_0  = 8'hFB;
	localparam logic [7:0]  ADDR_LOW_1  = 8'hE9;
	localparam logic [7:0]  ADDR_LOW_2  = 8'hEB;
	localparam logic [7:0]  ADDR_HIGH_0 = 8'hFC;
	localparam logic [7:0]  ADDR_HIGH_1 = 8'hEA;
	localparam logic [7:0]  ADDR_HIGH_2 = 8'hEC;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic        CMP_EN_RESET = 1'b0;
	localparam int          LOW_LSB     = 0;
	localparam int          HIGH_LSB    = 8;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccv_sfr_req_t;
endpackage : ccv_pkg

// >>> src/ccv_channel.sv
// one module's value, reload value, compare enable and output pin
`timescale 1ns/1ns
`default_nettype none
module ccv_channel (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        reload_select,
	input  wire logic        wr_low,
	input  wire logic        wr_high,
	input  wire logic [7:0]  wdata,
	input  wire logic        counter_match,
	output logic [15:0]      selected_value,
	output logic [15:0]      compare_value,
	output logic [15:0]      reload_value,
	output logic             compare_enable,
	output logic             module_output_pin
);
	logic [15:0] cmp_q;
	logic [15:0] rld_q;
	logic        en_q;
	logic        pin_q;

	// write port for the compare value
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cmp_q <= ccv_pkg::VALUE_RESET;
		end else if (!reload_select) begin
			if (wr_low)
				cmp_q[ccv_pkg::LOW_LSB +: 8] <= wdata;
			if (wr_high)
				cmp_q[ccv_pkg::HIGH_LSB +: 8] <= wdata;
		end
	end

	// write port for the auto-reload value
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rld_q <= ccv_pkg::VALUE_RESET;
		end else if (reload_select) begin
			if (wr_low)
				rld_q[ccv_pkg::LOW_LSB +: 8] <= wdata;
			if (wr_high)
				rld_q[ccv_pkg::HIGH_LSB +: 8] <= wdata;
		end
	end

	// enable follows writes whatever the reload selection
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			en_q <= ccv_pkg::CMP_EN_RESET;
		else if (wr_high)
			en_q <= 1'b1;
		else if (wr_low)
			en_q <= 1'b0;
	end

	// pin holds while disabled, so a value written low byte first never fires half-written
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			pin_q <= 1'b0;
		else if (counter_match && en_q)
			pin_q <= ~pin_q;
	end

	assign selected_value    = reload_select ? rld_q : cmp_q;
	assign compare_value     = cmp_q;
	assign reload_value      = rld_q;
	assign compare_enable    = en_q;
	assign module_output_pin = pin_q;

	chk_pin_hold_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!en_q |=> $stable(pin_q)) else $error("pin toggled while compare disabled");
	chk_pin_toggle_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(en_q && counter_match) |=> (pin_q != $past(pin_q))) else $error("pin missed toggle");
	chk_low_clears_en: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(wr_low && !wr_high) |=> !en_q) else $error("low write left enable set");
	chk_high_sets_en: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wr_high |=> en_q) else $error("high write left enable clear");
	chk_low_byte_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(wr_low && !reload_select) |=> cmp_q[7:0] == $past(wdata)) else $error("low byte lost");
	chk_high_byte_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(wr_high && !reload_select) |=> cmp_q[15:8] == $past(wdata)) else $error("high byte lost");
	chk_reload_isolated: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reload_select |=> $stable(cmp_q)) else $error("compare changed while reload selected");
	chk_en_no_spurious: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!wr_low && !wr_high) |=> $stable(en_q)) else $error("enable changed without write");
	cov_low_then_high: cover property (@(posedge sys_clk) disable iff (!reset_n)
		wr_low ##[1:4] wr_high);
	cov_reload_write: cover property (@(posedge sys_clk) disable iff (!reset_n)
		reload_select && wr_high);
	cov_match_blocked: cover property (@(posedge sys_clk) disable iff (!reset_n)
		counter_match && !en_q);
endmodule : ccv_channel
`default_nettype wire

// >>> test/capture_compare_value_regs_tb_top.sv
// self-checking bench for the capture/compare value register block
`timescale 1ns/1ns
`default_nettype none
module capture_compare_value_regs_tb_top;
	logic                  sys_clk, reset_n, reload_select, sfr_hit, rd_seen;
	ccv_pkg::ccv_sfr_req_t sfr_req;
	logic [2:0]            counter_match, compare_enable, module_output_pin;
	logic [7:0]            sfr_rdata;
	logic [47:0]           compare_value, reload_value;
	logic [8:0]            exp_q[$];
	logic [7:0]            lo_a[3], hi_a[3];
	logic [15:0]           v, r;
	int                    fail_count, checks;
	ccv_regs #(.NUM_MODULES(3)) ccv_regs_inst (.sys_clk, .reset_n, .sfr_req, .reload_select,
		.counter_match, .sfr_rdata, .sfr_hit, .compare_value, .reload_value,
		.compare_enable, .module_output_pin);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t read got %h exp %h", $time, got, exp);
		end
	endtask : cmp_rd
	task automatic cmp_st(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t state got %h exp %h", $time, got, exp);
		end
	endtask : cmp_st
	// one strobe cycle then an idle cycle, so no signal is driven twice in a step
	task automatic bus(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1 sfr_req = '{wr: w, rd: rr, addr: a, wdata: d};
		@(posedge sys_clk);
		#1 sfr_req = '0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [8:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic match(input int m);
		@(posedge sys_clk);
		#1 counter_match = 3'(1 << m);
		@(posedge sys_clk);
		#1 counter_match = 3'h0;
	endtask : match
	// read answer lands exactly one cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0) begin
			cmp_rd({sfr_hit, sfr_rdata}, exp_q.pop_front());
		end
		rd_seen <= sfr_req.rd & reset_n;
	end
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial begin
		reset_n = 1'b0;
		sfr_req = '0;
		reload_select = 1'b0;
		counter_match = 3'h0;
		rd_seen = 1'b0;
		lo_a = '{ccv_pkg::ADDR_LOW_0, ccv_pkg::ADDR_LOW_1, ccv_pkg::ADDR_LOW_2};
		hi_a = '{ccv_pkg::ADDR_HIGH_0, ccv_pkg::ADDR_HIGH_1, ccv_pkg::ADDR_HIGH_2};
		v = 16'($urandom(32'h2077));
		repeat (3) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		for (int m = 0; m < 3; m++) begin
			rd(lo_a[m], 9'h100);
			rd(hi_a[m], 9'h100);
		end
		cmp_st({13'h0, compare_enable}, 16'h0000);
		$display("test reset_values done");
		for (int m = 0; m < 3; m++) begin
			v = 16'($urandom);
			r = 16'($urandom);
			wr(lo_a[m], v[7:0]);
			cmp_st({15'h0, compare_enable[m]}, 16'h0000);
			wr(hi_a[m], v[15:8]);
			cmp_st({15'h0, compare_enable[m]}, 16'h0001);
			cmp_st(compare_value[16*m +: 16], v);
			rd(hi_a[m], {1'b1, v[15:8]});
			rd(lo_a[m], {1'b1, v[7:0]});
			cmp_st({15'h0, compare_enable[m]}, 16'h0001);
			match(m);
			cmp_st({15'h0, module_output_pin[m]}, 16'h0001);
			wr(lo_a[m], v[7:0]);
			match(m);
			cmp_st({14'h0, module_output_pin[m], compare_enable[m]}, 16'h0002);
			reload_select = 1'b1;
			wr(lo_a[m], r[7:0]);
			wr(hi_a[m], r[15:8]);
			cmp_st(reload_value[16*m +: 16], r);
			cmp_st(compare_value[16*m +: 16], v);
			rd(lo_a[m], {1'b1, r[7:0]});
			reload_select = 1'b0;
			rd(hi_a[m], {1'b1, v[15:8]});
		end
		$display("test module_values done");
		// unmapped neighbour of a mapped address must stay silent
		wr(8'hFD, 8'hA5);
		rd(8'hFD, 9'h000);
		cmp_st({13'h0, compare_enable}, 16'h0007);
		$display("test unmapped done");
		// mid-run reset must drop module 0's compare value, module 2's reload value, every enable and pin back to zero
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		cmp_st(compare_value[15:0], 16'h0000);
		cmp_st(reload_value[47:32], 16'h0000);
		cmp_st({10'h0, module_output_pin, compare_enable}, 16'h0000);
		rd(hi_a[1], 9'h100);
		$display("test mid_reset done");
		repeat (3) @(posedge sys_clk);
		print_verdict();
	end
endmodule : capture_compare_value_regs_tb_top
`default_nettype wire
